// ==== rtl/dpl_poll_base.sv ====
// Operation
// - transmit poll write checks transmit list
// - tx poll, none found: suspend, no flag
// - tx poll, descriptor found: resume transmit
// - tx poll while prefetched: recheck before suspend
// - receive poll write checks receive list
// - rx poll, none found: suspend, no flag
// - rx poll, descriptor found: resume receive
// - rx poll while prefetched: recheck before suspend
// - base registers hold ring start, bits 31:2
// - status write-one clears, reads harmless
// - status fields except bit 10 raise interrupt, individually maskable
// - bit 2 tx unavailable, normal summary
// - bit 7 rx unavailable, abnormal summary
`timescale 1ns/1ps
module dpl_poll_base
  import dpl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_index,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire dpl_proc_t tx_state,
  input wire dpl_proc_t rx_state,
  input wire logic [DPL_EVENT_BITS-1:0] dma_event,
  output logic transmit_poll_request,
  output logic receive_poll_request,
  output logic [31:0] transmit_ring_base,
  output logic [31:0] receive_ring_base,
  output logic host_irq
);
  logic [31:0] tx_base_reg;
  logic [31:0] rx_base_reg;
  logic [DPL_EVENT_BITS-1:0] status_reg;
  logic [DPL_EVENT_BITS-1:0] status_next;
  logic [DPL_EVENT_BITS-1:0] mask_reg;
  logic [31:0] rdata_next;
  logic tx_poll_reg;
  logic rx_poll_reg;

  // address decode
  wire wr_tx_poll = reg_wr && (reg_index == DPL_IDX_TX_POLL);
  wire wr_rx_poll = reg_wr && (reg_index == DPL_IDX_RX_POLL);
  wire wr_rx_base = reg_wr && (reg_index == DPL_IDX_RX_BASE);
  wire wr_tx_base = reg_wr && (reg_index == DPL_IDX_TX_BASE);
  wire wr_status = reg_wr && (reg_index == DPL_IDX_STATUS);
  wire wr_mask = reg_wr && (reg_index == DPL_IDX_MASK);
  // base writes only land while the matching process is stopped
  wire rx_base_ok = wr_rx_base && (rx_state == DPL_ST_STOPPED);
  wire tx_base_ok = wr_tx_base && (tx_state == DPL_ST_STOPPED);

  // status: new events win over a write-one clear in the same cycle
  wire [DPL_EVENT_BITS-1:0] clr_bits = wr_status ? reg_wdata[DPL_EVENT_BITS-1:0] : '0;
  assign status_next = (status_reg & ~clr_bits) | dma_event;
  // masked summaries
  wire [DPL_EVENT_BITS-1:0] live_bits = status_reg & ~mask_reg;
  wire normal_sum = |(live_bits & DPL_NORMAL_SET);
  wire abnormal_sum = |(live_bits & DPL_ABNORMAL_SET);

  // read mux; poll strobes read their reset pattern and have no read effect
  always_comb
  begin
    rdata_next = 32'h00000000;
    unique case (reg_index)
      DPL_IDX_TX_POLL: rdata_next = DPL_POLL_RESET;
      DPL_IDX_RX_POLL: rdata_next = DPL_POLL_RESET;
      DPL_IDX_RX_BASE: rdata_next = rx_base_reg;
      DPL_IDX_TX_BASE: rdata_next = tx_base_reg;
      DPL_IDX_STATUS:
        rdata_next = {15'h0000, normal_sum, abnormal_sum, status_reg};
      DPL_IDX_MASK: rdata_next = {17'h00000, mask_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // any data value triggers a poll; one-cycle pulse
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_poll_reg <= 1'b0;
      rx_poll_reg <= 1'b0;
    end
    else
    begin
      tx_poll_reg <= wr_tx_poll;
      rx_poll_reg <= wr_rx_poll;
    end
  end

  // ring bases: bits 1:0 stored as written, host keeps them zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_base_reg <= DPL_BASE_RESET;
      tx_base_reg <= DPL_BASE_RESET;
    end
    else
    begin
      if (rx_base_ok)
        rx_base_reg <= reg_wdata;
      if (tx_base_ok)
        tx_base_reg <= reg_wdata;
    end
  end

  // status, mask and read data
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      status_reg <= '0;
      mask_reg <= DPL_MASK_RESET[DPL_EVENT_BITS-1:0];
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      status_reg <= status_next;
      if (wr_mask)
        mask_reg <= reg_wdata[DPL_EVENT_BITS-1:0];
      if (reg_rd)
        reg_rdata <= rdata_next;
    end
  end

  // the dma engine performs the recheck, resume and suspend on each pulse;
  // a poll never sets the unavailable bits itself
  assign transmit_poll_request = tx_poll_reg;
  assign receive_poll_request = rx_poll_reg;
  assign transmit_ring_base = tx_base_reg;
  assign receive_ring_base = rx_base_reg;
  assign host_irq = normal_sum | abnormal_sum;

  chk_tx_poll_pulse: assert property (@(posedge core_clk) disable iff (rst)
    wr_tx_poll |=> transmit_poll_request ##1 (!transmit_poll_request || $past(wr_tx_poll)))
    else $error("tx poll pulse wrong");
  chk_rx_poll_pulse: assert property (@(posedge core_clk) disable iff (rst)
    receive_poll_request |-> $past(wr_rx_poll))
    else $error("rx poll without write");
  chk_tx_poll_cause: assert property (@(posedge core_clk) disable iff (rst)
    transmit_poll_request |-> $past(wr_tx_poll))
    else $error("tx poll without write");
  chk_rx_base_lock: assert property (@(posedge core_clk) disable iff (rst)
    (wr_rx_base && rx_state != DPL_ST_STOPPED) |=> $stable(receive_ring_base))
    else $error("rx base changed while active");
  chk_tx_base_load: assert property (@(posedge core_clk) disable iff (rst)
    tx_base_ok |=> transmit_ring_base == $past(reg_wdata))
    else $error("tx base not loaded");
  chk_status_clear: assert property (@(posedge core_clk) disable iff (rst)
    (wr_status && reg_wdata[DPL_BIT_TX_UNAVAIL] && !dma_event[DPL_BIT_TX_UNAVAIL])
      |=> !status_reg[DPL_BIT_TX_UNAVAIL])
    else $error("status bit not cleared");
  chk_status_hold: assert property (@(posedge core_clk) disable iff (rst)
    !wr_status |=> (status_reg & $past(status_reg)) == $past(status_reg))
    else $error("status bit lost without write");
  chk_rx_unavail_sum: assert property (@(posedge core_clk) disable iff (rst)
    (status_reg[DPL_BIT_RX_UNAVAIL] && !mask_reg[DPL_BIT_RX_UNAVAIL]) |-> abnormal_sum)
    else $error("rx unavailable not summarised");
  chk_tx_unavail_sum: assert property (@(posedge core_clk) disable iff (rst)
    (status_reg[DPL_BIT_TX_UNAVAIL] && !mask_reg[DPL_BIT_TX_UNAVAIL]) |-> normal_sum)
    else $error("tx unavailable not summarised");
  chk_mask_quiet: assert property (@(posedge core_clk) disable iff (rst)
    ((status_reg & ~mask_reg) == '0) |-> !host_irq)
    else $error("masked bits raise irq");

  // receive side of the poll pulse, same shape as the transmit one
  chk_rx_poll_follow: assert property (@(posedge core_clk) disable iff (rst)
    wr_rx_poll |=> receive_poll_request ##1 (!receive_poll_request || $past(wr_rx_poll)))
    else $error("rx poll pulse wrong");
  // reads share the bus with poll writes but must never start a poll
  chk_poll_read_quiet: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd && !reg_wr) |=> (!transmit_poll_request && !receive_poll_request))
    else $error("read started a poll");
  // a poll alone never raises the unavailable flags; only the dma may
  chk_tx_no_flag: assert property (@(posedge core_clk) disable iff (rst)
    (transmit_poll_request && !status_reg[DPL_BIT_TX_UNAVAIL] && !dma_event[DPL_BIT_TX_UNAVAIL])
      |=> !status_reg[DPL_BIT_TX_UNAVAIL])
    else $error("tx poll raised flag");
  chk_rx_no_flag: assert property (@(posedge core_clk) disable iff (rst)
    (receive_poll_request && !status_reg[DPL_BIT_RX_UNAVAIL] && !dma_event[DPL_BIT_RX_UNAVAIL])
      |=> !status_reg[DPL_BIT_RX_UNAVAIL])
    else $error("rx poll raised flag");

  // ring bases: loaded only when allowed, otherwise frozen
  chk_rx_base_load: assert property (@(posedge core_clk) disable iff (rst)
    rx_base_ok |=> receive_ring_base == $past(reg_wdata))
    else $error("rx base not loaded");
  chk_tx_base_lock: assert property (@(posedge core_clk) disable iff (rst)
    (wr_tx_base && tx_state != DPL_ST_STOPPED) |=> $stable(transmit_ring_base))
    else $error("tx base changed while active");
  // a running dma would follow a moved ring pointer mid-list, so no other path may move it
  chk_rx_base_hold: assert property (@(posedge core_clk) disable iff (rst)
    !rx_base_ok |=> $stable(receive_ring_base))
    else $error("rx base moved without write");
  chk_tx_base_hold: assert property (@(posedge core_clk) disable iff (rst)
    !tx_base_ok |=> $stable(transmit_ring_base))
    else $error("tx base moved without write");

  // status and mask: clears by one, events never lost to a clear
  chk_rx_unavail_clear: assert property (@(posedge core_clk) disable iff (rst)
    (wr_status && reg_wdata[DPL_BIT_RX_UNAVAIL] && !dma_event[DPL_BIT_RX_UNAVAIL])
      |=> !status_reg[DPL_BIT_RX_UNAVAIL])
    else $error("rx status bit not cleared");
  chk_event_wins: assert property (@(posedge core_clk) disable iff (rst)
    (dma_event != '0) |=> ((status_reg & $past(dma_event)) == $past(dma_event)))
    else $error("event lost");
  chk_mask_load: assert property (@(posedge core_clk) disable iff (rst)
    wr_mask |=> mask_reg == $past(reg_wdata[DPL_EVENT_BITS-1:0]))
    else $error("mask not loaded");
  chk_read_summary: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd && reg_index == DPL_IDX_STATUS)
      |=> (reg_rdata[DPL_BIT_NIS] == $past(normal_sum))
        && (reg_rdata[DPL_BIT_AIS] == $past(abnormal_sum)))
    else $error("summary bits misread");

  cov_tx_poll: cover property (@(posedge core_clk) disable iff (rst) transmit_poll_request);
  cov_rx_poll: cover property (@(posedge core_clk) disable iff (rst) receive_poll_request);
  cov_base_blocked: cover property (@(posedge core_clk) disable iff (rst)
    wr_tx_base && tx_state == DPL_ST_RUNNING);
  cov_set_clear: cover property (@(posedge core_clk) disable iff (rst)
    wr_status && |(reg_wdata[DPL_EVENT_BITS-1:0] & dma_event));
  cov_irq_masked: cover property (@(posedge core_clk) disable iff (rst)
    (status_reg != '0) && !host_irq);
endmodule

// ==== pkg/dpl_pkg.sv ====
package dpl_pkg;
  // register indices; no offsets are printed, so byte address is index times four
  localparam logic [3:0] DPL_IDX_TX_POLL = 4'h1;
  localparam logic [3:0] DPL_IDX_RX_POLL = 4'h2;
  localparam logic [3:0] DPL_IDX_RX_BASE = 4'h3;
  localparam logic [3:0] DPL_IDX_TX_BASE = 4'h4;
  localparam logic [3:0] DPL_IDX_STATUS = 4'h5;
  localparam logic [3:0] DPL_IDX_MASK = 4'h7;
  // reset values
  localparam logic [31:0] DPL_POLL_RESET = 32'h0FFFFFFF;
  localparam logic [31:0] DPL_BASE_RESET = 32'h00000000;
  localparam logic [31:0] DPL_MASK_RESET = 32'h00000000;
  // status field positions
  localparam int DPL_BIT_TX_UNAVAIL = 2;
  localparam int DPL_BIT_RX_UNAVAIL = 7;
  localparam int DPL_BIT_AIS = 15;
  localparam int DPL_BIT_NIS = 16;
  localparam int DPL_EVENT_BITS = 15;
  // bits 0..14 that feed the normal summary
  localparam logic [14:0] DPL_NORMAL_SET = 15'h4845;
  // bits 0..14 that feed the abnormal summary
  localparam logic [14:0] DPL_ABNORMAL_SET = 15'h33BA;
  // process state, as the dma reports it
  typedef enum logic [1:0] {
    DPL_ST_STOPPED,
    DPL_ST_RUNNING,
    DPL_ST_SUSPENDED
  } dpl_proc_t;
endpackage

// ==== testbench/dpl_dma_model.sv ====
`timescale 1ns/1ps
module dpl_dma_model
  import dpl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tx_poll,
  input wire logic rx_poll,
  input wire logic desc_avail,
  input wire logic run_cmd,
  output dpl_proc_t tx_state,
  output dpl_proc_t rx_state
);
  // a poll resumes on an owned descriptor, else suspends without a flag
  function automatic dpl_proc_t nxt(input dpl_proc_t cur, input logic poll);
    if (!run_cmd)
      return DPL_ST_STOPPED;
    if (poll)
      return desc_avail ? DPL_ST_RUNNING : DPL_ST_SUSPENDED;
    return (cur == DPL_ST_STOPPED) ? DPL_ST_RUNNING : cur;
  endfunction
  // both processes stop together when the start command drops
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_state <= DPL_ST_STOPPED;
      rx_state <= DPL_ST_STOPPED;
    end
    else
    begin
      tx_state <= nxt(tx_state, tx_poll);
      rx_state <= nxt(rx_state, rx_poll);
    end
  end
endmodule

// ==== testbench/dpl_poll_base_tb.sv ====
`timescale 1ns/1ps
module dpl_poll_base_tb;
  import dpl_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_index = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [14:0] dma_event = 15'h0;
  logic desc_avail = 1'b0;
  logic run_cmd = 1'b0;
  logic [31:0] reg_rdata, tx_base, rx_base;
  logic tx_req, rx_req, host_irq;
  dpl_proc_t tx_state, rx_state;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2.5 core_clk = ~core_clk;
  dpl_poll_base i_dpl_poll_base (.core_clk(core_clk), .rst(rst), .reg_index(reg_index),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_state(tx_state), .rx_state(rx_state), .dma_event(dma_event),
    .transmit_poll_request(tx_req), .receive_poll_request(rx_req),
    .transmit_ring_base(tx_base), .receive_ring_base(rx_base), .host_irq(host_irq));
  dpl_dma_model i_dpl_dma_model (.core_clk(core_clk), .rst(rst), .tx_poll(tx_req),
    .rx_poll(rx_req), .desc_avail(desc_avail), .run_cmd(run_cmd), .tx_state(tx_state),
    .rx_state(rx_state));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one-cycle strobes, released at the edge that took them
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    reg_index <= idx;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
    @(posedge core_clk);
    reg_index <= idx;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic ev(input logic [14:0] e);
    @(posedge core_clk);
    dma_event <= e;
    @(posedge core_clk);
    dma_event <= 15'h0;
  endtask
  task automatic t_base();
    rd(DPL_IDX_TX_POLL, DPL_POLL_RESET);
    rd(DPL_IDX_RX_POLL, DPL_POLL_RESET);
    rd(4'h6, 32'h0); // unmapped index reads zero
    wr(DPL_IDX_RX_BASE, 32'h12345678);
    wr(DPL_IDX_TX_BASE, 32'hABCDEF00);
    chk(rx_base, 32'h12345678);
    rd(DPL_IDX_TX_BASE, 32'hABCDEF00);
    @(posedge core_clk);
    run_cmd <= 1'b1;
    wr(DPL_IDX_RX_BASE, 32'h0); // refused while running
    chk(rx_base, 32'h12345678);
    wr(DPL_IDX_TX_BASE, 32'h0); // refused while running
    chk(tx_base, 32'hABCDEF00);
  endtask
  task automatic t_poll();
    wr(DPL_IDX_TX_POLL, 32'h1);
    chk({tx_req, rx_req}, 32'h2);
    @(posedge core_clk);
    #1;
    chk({tx_req, rx_req}, 32'h0);
    @(posedge core_clk);
    desc_avail <= 1'b1;
    wr(DPL_IDX_RX_POLL, 32'h00000000); // even bit 0 clear polls
    chk({tx_req, rx_req}, 32'h1);
    rd(DPL_IDX_STATUS, 32'h0); // suspend leaves no flag
  endtask
  task automatic t_status();
    ev(15'h0004);
    rd(DPL_IDX_STATUS, 32'h00010004);
    rd(DPL_IDX_STATUS, 32'h00010004);
    chk(host_irq, 1'b1);
    wr(DPL_IDX_MASK, 32'h4);
    chk(host_irq, 1'b0);
    wr(DPL_IDX_MASK, 32'h0);
    wr(DPL_IDX_STATUS, 32'h0);
    rd(DPL_IDX_STATUS, 32'h00010004);
    wr(DPL_IDX_STATUS, 32'h4);
    ev(15'h0080);
    rd(DPL_IDX_STATUS, 32'h00008080);
    wr(DPL_IDX_STATUS, 32'h80);
    rd(DPL_IDX_STATUS, 32'h0);
  endtask
  // clear and new event in one cycle: the event must survive
  task automatic t_race();
    ev(15'h0004);
    @(posedge core_clk);
    reg_index <= DPL_IDX_STATUS;
    reg_wdata <= 32'h00000004;
    reg_wr <= 1'b1;
    dma_event <= 15'h0004;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    dma_event <= 15'h0000;
    rd(DPL_IDX_STATUS, 32'h00010004);
  endtask
  // reset in mid-run, with a flag pending and a base loaded
  task automatic t_reset();
    chk(host_irq, 1'b1);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(rx_base, DPL_BASE_RESET);
    chk({tx_req, rx_req, host_irq}, 32'h0);
    @(posedge core_clk);
    rst <= 1'b0;
    rd(DPL_IDX_STATUS, 32'h0);
    rd(DPL_IDX_TX_BASE, DPL_BASE_RESET);
  endtask
  // hang guard, far above the fewer than a hundred cycles needed
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_base();
    t_poll();
    t_status();
    t_race();
    t_reset();
    wrap_up();
  end
endmodule
